// ==== aiswc_pkg.sv ====
// Package of constants and types for the analog input select and window compare block
package aiswc_pkg;
  // Sample and limit widths: inputs are signed percent in tenths (-1000..1000)
  localparam int SAMPLE_W      = 12;
  localparam int ACC_W         = 18;
  localparam int CODE_W        = 3;
  localparam int FILT_W        = 5;
  // Frequency source code that selects the analog path
  localparam logic [1:0] FSRC_ANALOG = 2'h1;
  // Pair select codes
  localparam logic [2:0] PAIR_V_I    = 3'h0;
  localparam logic [2:0] PAIR_V_B    = 3'h1;
  localparam logic [2:0] PAIR_V_K    = 3'h2;
  localparam logic [2:0] PAIR_I_K    = 3'h3;
  localparam logic [2:0] PAIR_B_K    = 3'h4;
  // Trim mode codes
  localparam logic [1:0] TRIM_NONE   = 2'h0;
  localparam logic [1:0] TRIM_UNI    = 2'h1;
  localparam logic [1:0] TRIM_REV    = 2'h2;
  localparam logic [1:0] TRIM_NONE3  = 2'h3;
  // Filter setting range
  localparam logic [4:0] FILT_MIN    = 5'h01;
  localparam logic [4:0] FILT_MAX    = 5'h1E;
  localparam int         FILT_DEPTH  = 30;
  // Comparator ranges in tenths of a percent
  localparam logic signed [11:0] PCT_ZERO  = 12'sh000;
  localparam logic signed [11:0] PCT_FULL  = 12'sh3E8;
  localparam logic signed [11:0] PCT_NFULL = -12'sh3E8;
  localparam logic signed [11:0] HYST_MAX  = 12'sh064;
  // Intelligent output option codes for the three comparator flags
  localparam logic [7:0] OPT_VOLT_WIN = 8'h36;
  localparam logic [7:0] OPT_CURR_WIN = 8'h37;
  localparam logic [7:0] OPT_SIGN_WIN = 8'h38;
  // Source that drives the main command
  typedef enum logic [4:0] {
    SRC_VOLT = 5'b00001,
    SRC_CURR = 5'b00010,
    SRC_SIGN = 5'b00100,
    SRC_KPAD = 5'b01000,
    SRC_SUM  = 5'b10000
  } aiswc_src_t;
endpackage

// ==== aiswc_filter.sv ====
// Moving average filter with a run-time length of 1 to 30 samples
module aiswc_filter
  import aiswc_pkg::*;
#(
  parameter int DEPTH = FILT_DEPTH
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Sample stream
  input  wire logic                       sample_stb,
  input  wire logic signed [SAMPLE_W-1:0] sample_in,
  input  wire logic        [FILT_W-1:0]   length,
  // Filtered value
  output logic signed [SAMPLE_W-1:0]      avg_out
);
  typedef struct packed {
    logic signed [DEPTH-1:0][SAMPLE_W-1:0] hist;
    logic signed [SAMPLE_W-1:0]            avg;
  } aiswc_filt_st_t;

  aiswc_filt_st_t st_reg;
  aiswc_filt_st_t st_next;

  // Clamp the length so an out-of-range setting still averages sensibly
  function automatic int clamp_len(input logic [FILT_W-1:0] l);
    if (l < FILT_MIN) return 1;
    if (l > FILT_MAX) return DEPTH;
    return int'(l);
  endfunction

  // Shift the history and sum the newest N samples
  always_comb begin
    logic signed [ACC_W-1:0] sum;
    int n;
    sum = '0;
    n = clamp_len(length);
    st_next = st_reg;
    if (sample_stb) begin
      st_next.hist = {st_reg.hist[DEPTH-2:0], sample_in};
      for (int k = 0; k < DEPTH; k++) begin
        if (k < n) begin
          sum = sum + ACC_W'(signed'(st_next.hist[k])); // Element selects read unsigned
        end
      end
      st_next.avg = SAMPLE_W'(sum / ACC_W'(n));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avg_out = st_reg.avg;

  // A length of one passes the sample straight through
  one_tap_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sample_stb && length == FILT_MIN |=> avg_out == $past(sample_in))
    else $error("length one filter does not pass sample");
endmodule // aiswc_filter

// ==== aiswc_window.sv ====
// Window comparator with hysteresis and threshold substitution
module aiswc_window
  import aiswc_pkg::*;
#(
  parameter logic signed [SAMPLE_W-1:0] RANGE_LO = PCT_ZERO
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Value and limits
  input  wire logic signed [SAMPLE_W-1:0] value_in,
  input  wire logic signed [SAMPLE_W-1:0] upper_in,
  input  wire logic signed [SAMPLE_W-1:0] lower_in,
  input  wire logic signed [SAMPLE_W-1:0] hyst_in,
  // Results
  output logic                            window_flag,
  output logic signed [SAMPLE_W-1:0]      value_out
);
  typedef struct packed {
    logic                       flag;
    logic signed [SAMPLE_W-1:0] val;
  } aiswc_win_st_t;

  aiswc_win_st_t st_reg;
  aiswc_win_st_t st_next;

  function automatic logic signed [SAMPLE_W-1:0] clip(
      input logic signed [SAMPLE_W-1:0] v,
      input logic signed [SAMPLE_W-1:0] lo,
      input logic signed [SAMPLE_W-1:0] hi);
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction

  // Limits are clipped to range, then upper is raised to at least lower plus twice hysteresis
  always_comb begin
    logic signed [SAMPLE_W-1:0] h;
    logic signed [SAMPLE_W-1:0] lo;
    logic signed [SAMPLE_W-1:0] hi;
    logic signed [SAMPLE_W-1:0] hmin;
    h    = clip(hyst_in, PCT_ZERO, HYST_MAX);
    lo   = clip(lower_in, RANGE_LO, PCT_FULL);
    hi   = clip(upper_in, RANGE_LO, PCT_FULL);
    hmin = SAMPLE_W'(lo + (h <<< 1));
    if (hi < hmin) begin
      hi = hmin;
    end
    st_next = st_reg;
    // Entering needs to clear the edge by h; leaving needs to cross the edge
    if (st_reg.flag) begin
      if (value_in < lo || value_in > hi) begin
        st_next.flag = 1'b0;
      end
    end else if (value_in >= SAMPLE_W'(lo + h) && value_in <= SAMPLE_W'(hi - h)) begin
      st_next.flag = 1'b1;
    end
    st_next.val = (value_in < lo) ? lo : value_in;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign window_flag = st_reg.flag;
  assign value_out   = st_reg.val;

  // Output never falls below the substituted threshold
  substitute_floor_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n) |-> value_out >= clip($past(lower_in), RANGE_LO, PCT_FULL))
    else $error("output below threshold");
endmodule // aiswc_window

// ==== aiswc_select.sv ====
// Analog input select and window compare top: filters, comparators, source selection
module aiswc_select
  import aiswc_pkg::*;
(
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  // Analog samples, tenths of a percent, from converters on this clock
  input  wire logic                       sample_stb,
  input  wire logic signed [SAMPLE_W-1:0] voltage_input,
  input  wire logic signed [SAMPLE_W-1:0] current_loop_input,
  input  wire logic signed [SAMPLE_W-1:0] signed_voltage_input,
  input  wire logic signed [SAMPLE_W-1:0] keypad_pot_input,
  // Select terminal, from a pin
  input  wire logic                       analog_type_select,
  input  wire logic                       select_assigned,
  // Configuration
  input  wire logic [1:0]                 frequency_source_param,
  input  wire logic [CODE_W-1:0]          pair_select_param,
  input  wire logic [1:0]                 trim_mode_param,
  input  wire logic [FILT_W-1:0]          input_filter_param,
  // Window settings
  input  wire logic signed [SAMPLE_W-1:0] voltage_window_upper,
  input  wire logic signed [SAMPLE_W-1:0] voltage_window_lower,
  input  wire logic signed [SAMPLE_W-1:0] voltage_window_hyst,
  input  wire logic signed [SAMPLE_W-1:0] current_window_upper,
  input  wire logic signed [SAMPLE_W-1:0] current_window_lower,
  input  wire logic signed [SAMPLE_W-1:0] current_window_hyst,
  input  wire logic signed [SAMPLE_W-1:0] signed_window_upper,
  input  wire logic signed [SAMPLE_W-1:0] signed_window_lower,
  input  wire logic signed [SAMPLE_W-1:0] signed_window_hyst,
  // Command outputs
  output logic                            command_valid,
  output logic        [SAMPLE_W-1:0]      command_magnitude,
  output logic                            command_reverse,
  output logic                            trim_active,
  output logic                            reverse_permitted,
  // Window flags
  output logic                            voltage_window_flag,
  output logic                            current_window_flag,
  output logic                            signed_window_flag
);
  typedef struct packed {
    logic                       sel_meta;
    logic                       sel_sync;
    logic                       valid;
    logic [SAMPLE_W-1:0]        mag;
    logic                       rev;
    logic                       trim;
    logic                       rev_ok;
  } aiswc_st_t;

  aiswc_st_t st_reg;
  aiswc_st_t st_next;

  logic signed [SAMPLE_W-1:0] filt_v;
  logic signed [SAMPLE_W-1:0] filt_i;
  logic signed [SAMPLE_W-1:0] filt_b;
  logic signed [SAMPLE_W-1:0] win_v;
  logic signed [SAMPLE_W-1:0] win_i;
  logic signed [SAMPLE_W-1:0] win_b;

  // Same filter length for every stream
  aiswc_filter u_filt_v (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .sample_stb (sample_stb),
    .sample_in  (voltage_input),
    .length     (input_filter_param),
    .avg_out    (filt_v)
  );
  aiswc_filter u_filt_i (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .sample_stb (sample_stb),
    .sample_in  (current_loop_input),
    .length     (input_filter_param),
    .avg_out    (filt_i)
  );
  aiswc_filter u_filt_b (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .sample_stb (sample_stb),
    .sample_in  (signed_voltage_input),
    .length     (input_filter_param),
    .avg_out    (filt_b)
  );

  // One comparator per monitored input
  aiswc_window #(.RANGE_LO(PCT_ZERO)) u_win_v (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .value_in    (filt_v),
    .upper_in    (voltage_window_upper),
    .lower_in    (voltage_window_lower),
    .hyst_in     (voltage_window_hyst),
    .window_flag (voltage_window_flag),
    .value_out   (win_v)
  );
  aiswc_window #(.RANGE_LO(PCT_ZERO)) u_win_i (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .value_in    (filt_i),
    .upper_in    (current_window_upper),
    .lower_in    (current_window_lower),
    .hyst_in     (current_window_hyst),
    .window_flag (current_window_flag),
    .value_out   (win_i)
  );
  aiswc_window #(.RANGE_LO(PCT_NFULL)) u_win_b (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .value_in    (filt_b),
    .upper_in    (signed_window_upper),
    .lower_in    (signed_window_lower),
    .hyst_in     (signed_window_hyst),
    .window_flag (signed_window_flag),
    .value_out   (win_b)
  );

  // Saturating add so trim cannot wrap the command
  function automatic logic signed [SAMPLE_W-1:0] sat_add(
      input logic signed [SAMPLE_W-1:0] a,
      input logic signed [SAMPLE_W-1:0] b);
    logic signed [SAMPLE_W:0] s;
    s = (SAMPLE_W+1)'(a) + (SAMPLE_W+1)'(b);
    if (s > (SAMPLE_W+1)'(PCT_FULL))  return PCT_FULL;
    if (s < (SAMPLE_W+1)'(PCT_NFULL)) return PCT_NFULL;
    return SAMPLE_W'(s);
  endfunction

  // Source selection, trim and reverse permission
  always_comb begin
    aiswc_src_t               src;
    logic                     use_trim;
    logic                     rev_ok;
    logic signed [SAMPLE_W-1:0] main;
    logic signed [SAMPLE_W-1:0] cmd;
    src      = SRC_VOLT;
    use_trim = 1'b0;
    rev_ok   = 1'b0;
    main     = '0;
    cmd      = '0;
    st_next  = st_reg;
    // Select pin passes two flip-flops before any logic sees it
    st_next.sel_meta = analog_type_select;
    st_next.sel_sync = st_reg.sel_meta;
    if (!select_assigned) begin
      // Pair code plays no part here
      if (trim_mode_param == TRIM_NONE) begin
        src    = SRC_SIGN;
        rev_ok = 1'b1;
      end else begin
        src      = SRC_SUM;
        use_trim = (trim_mode_param == TRIM_UNI) || (trim_mode_param == TRIM_REV);
        rev_ok   = (trim_mode_param == TRIM_REV);
      end
    end else begin
      case (pair_select_param)
        PAIR_V_I: src = st_reg.sel_sync ? SRC_CURR : SRC_VOLT;
        PAIR_V_B: src = st_reg.sel_sync ? SRC_SIGN : SRC_VOLT;
        PAIR_V_K: src = st_reg.sel_sync ? SRC_KPAD : SRC_VOLT;
        PAIR_I_K: src = st_reg.sel_sync ? SRC_KPAD : SRC_CURR;
        PAIR_B_K: src = st_reg.sel_sync ? SRC_KPAD : SRC_SIGN;
        default:  src = st_reg.sel_sync ? SRC_CURR : SRC_VOLT;
      endcase
      // Codes 5 to 7 fall back to the voltage/current pair and its trim rule
      if (pair_select_param >= PAIR_V_K && pair_select_param <= PAIR_B_K) begin
        use_trim = (src != SRC_SIGN);
        rev_ok   = (src == SRC_SIGN);
      end else begin
        use_trim = (src != SRC_SIGN) &&
                   (trim_mode_param == TRIM_UNI || trim_mode_param == TRIM_REV);
        rev_ok   = (trim_mode_param == TRIM_REV) || (src == SRC_SIGN);
      end
    end
    case (src)
      SRC_VOLT: main = win_v;
      SRC_CURR: main = win_i;
      SRC_SIGN: main = win_b;
      SRC_KPAD: main = keypad_pot_input;
      SRC_SUM:  main = sat_add(win_v, win_i);
      default:  main = win_v;
    endcase
    cmd = use_trim ? sat_add(main, win_b) : main;
    // Unipolar trim mode never yields reverse
    if (trim_mode_param == TRIM_UNI) begin
      rev_ok = 1'b0;
    end
    st_next.valid  = (frequency_source_param == FSRC_ANALOG);
    st_next.trim   = use_trim;
    st_next.rev_ok = rev_ok;
    if (!st_next.valid) begin
      st_next.mag = '0;
      st_next.rev = 1'b0;
    end else if (cmd < PCT_ZERO) begin
      // Negative command reverses only when permitted, else clamps to zero
      st_next.rev = rev_ok;
      st_next.mag = rev_ok ? SAMPLE_W'(-cmd) : '0;
    end else begin
      st_next.rev = 1'b0;
      st_next.mag = SAMPLE_W'(cmd);
    end
  end

  // Synchronous reset clears the synchroniser and the command together
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every command output comes straight from a flip-flop
  assign command_valid     = st_reg.valid;
  assign command_magnitude = st_reg.mag;
  assign command_reverse   = st_reg.rev;
  assign trim_active       = st_reg.trim;
  assign reverse_permitted = st_reg.rev_ok;

  // Checks on the registered outputs and synchroniser, one cycle after the inputs that cause them, two for sel_sync_a; rev_needs_ok_a checks outputs in one cycle
  no_source_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frequency_source_param != FSRC_ANALOG |=> !command_valid && command_magnitude == '0)
    else $error("command driven without analog source");

  uni_no_rev_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    trim_mode_param == TRIM_UNI |=> !command_reverse && !reverse_permitted)
    else $error("reverse under unipolar trim mode");

  rev_needs_ok_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    command_reverse |-> reverse_permitted && command_valid)
    else $error("reverse without permission");

  keypad_no_rev_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    select_assigned && st_reg.sel_sync && pair_select_param >= PAIR_V_K
      && pair_select_param <= PAIR_B_K |=> !reverse_permitted && trim_active)
    else $error("keypad selection permits reverse or lacks trim");

  volt_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    select_assigned && !st_reg.sel_sync && pair_select_param == PAIR_V_I
      && trim_mode_param == TRIM_NONE && frequency_source_param == FSRC_ANALOG
      && win_v >= PCT_ZERO |=> command_magnitude == $past(win_v))
    else $error("voltage input not selected");

  curr_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    select_assigned && st_reg.sel_sync && pair_select_param == PAIR_V_I
      && trim_mode_param == TRIM_NONE && frequency_source_param == FSRC_ANALOG
      && win_i >= PCT_ZERO |=> command_magnitude == $past(win_i))
    else $error("current input not selected");

  unassigned_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !select_assigned && trim_mode_param == TRIM_NONE |=> reverse_permitted && !trim_active)
    else $error("unassigned code 00 wrong");

  sel_sync_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $past(rst_n, 2) |-> st_reg.sel_sync == $past(analog_type_select, 2))
    else $error("select input not synchronised in two stages");

  bip_main_rev_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    select_assigned && st_reg.sel_sync && pair_select_param == PAIR_V_B
      && trim_mode_param != TRIM_UNI |=> reverse_permitted && !trim_active)
    else $error("bipolar main lacks reverse or adds trim");

  no_trim_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    select_assigned && pair_select_param <= PAIR_V_B
      && (trim_mode_param == TRIM_NONE || trim_mode_param == TRIM_NONE3) |=> !trim_active)
    else $error("trim added under a no-trim code");

  odd_pair_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    select_assigned && pair_select_param > PAIR_B_K && trim_mode_param == TRIM_NONE3
      |=> !trim_active && !reverse_permitted)
    else $error("unused pair code does not act as code 00");

  sum_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !select_assigned && trim_mode_param == TRIM_NONE3 && frequency_source_param == FSRC_ANALOG
      |=> command_magnitude == SAMPLE_W'(sat_add($past(win_v), $past(win_i))))
    else $error("unassigned sum command wrong");

  bip_reverse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !select_assigned && trim_mode_param == TRIM_NONE && frequency_source_param == FSRC_ANALOG
      && win_b < PCT_ZERO |=> command_reverse && command_magnitude == SAMPLE_W'(-$past(win_b)))
    else $error("negative bipolar command not reversed");
endmodule // aiswc_select

// ==== aiswc_src_model.sv ====
// Model of the analog converters that feed samples into the select block
module aiswc_src_model
  import aiswc_pkg::*;
(
  // Clock
  input  wire logic               sys_clk,
  // Sample lines toward the block
  output logic                    sample_stb,
  output logic signed [SAMPLE_W-1:0] voltage_input,
  output logic signed [SAMPLE_W-1:0] current_loop_input,
  output logic signed [SAMPLE_W-1:0] signed_voltage_input
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle lines start at zero with no strobe
  initial begin
    sample_stb = 1'b0;
    voltage_input = '0;
    current_loop_input = '0;
    signed_voltage_input = '0;
  end

  // Burst of n strobes, one reading per line; afterwards the lines carry junk,
  // so a block that samples without a strobe shows up as a wrong result
  task automatic push(input logic signed [SAMPLE_W-1:0] v, i, b, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge sys_clk);
      #1;
      sample_stb = 1'b1;
      voltage_input = v;
      current_loop_input = i;
      signed_voltage_input = b;
    end
    @(posedge sys_clk);
    #1;
    sample_stb = 1'b0;
    voltage_input = ~v;
    current_loop_input = ~i;
    signed_voltage_input = ~b;
  endtask
endmodule // aiswc_src_model

// ==== test_analog_input_select_window_compare.sv ====
// Self-checking bench for the analog input select and window compare block
module test_analog_input_select_window_compare
  import aiswc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Stimulus and observed signals, named as the ports
  logic                       sys_clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       sample_stb;
  logic signed [SAMPLE_W-1:0] voltage_input, current_loop_input, signed_voltage_input;
  logic signed [SAMPLE_W-1:0] keypad_pot_input = '0;
  logic                       analog_type_select = 1'b0;
  logic                       select_assigned = 1'b1;
  logic [1:0]                 frequency_source_param = FSRC_ANALOG;
  logic [CODE_W-1:0]          pair_select_param = PAIR_V_I;
  logic [1:0]                 trim_mode_param = TRIM_NONE3;
  logic [FILT_W-1:0]          input_filter_param = FILT_MIN;
  logic signed [SAMPLE_W-1:0] voltage_window_upper, voltage_window_lower, voltage_window_hyst;
  logic signed [SAMPLE_W-1:0] current_window_upper, current_window_lower, current_window_hyst;
  logic signed [SAMPLE_W-1:0] signed_window_upper, signed_window_lower, signed_window_hyst;
  logic                       command_valid, command_reverse, trim_active, reverse_permitted;
  logic        [SAMPLE_W-1:0] command_magnitude;
  logic                       voltage_window_flag, current_window_flag, signed_window_flag;
  // Bench state
  int                         n_errors = 0;
  int                         total_checks = 0;
  int                         vi, ii, bi;
  logic                       e_vld, e_rev, e_trm, e_rvp;
  logic        [SAMPLE_W-1:0] e_mag;
  int wv[9] = '{100, 240, 500, 220, 150, 770, 600, 790, 850};
  int wm[9] = '{200, 240, 500, 220, 200, 770, 600, 790, 850};
  logic wf[9] = '{0, 0, 1, 1, 0, 0, 1, 1, 0};

  aiswc_select dut_u (.*);
  aiswc_src_model src_u (.*);

  // Free-running clock
  always #25 sys_clk = ~sys_clk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_val(input logic [SAMPLE_W-1:0] got, input logic [SAMPLE_W-1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t magnitude got %0d exp %0d", $time, got, exp);
    end
  endtask

  // Full-range windows with no hysteresis, so no value is substituted
  task automatic wide();
    voltage_window_upper = PCT_FULL;
    voltage_window_lower = PCT_ZERO;
    voltage_window_hyst = PCT_ZERO;
    current_window_upper = PCT_FULL;
    current_window_lower = PCT_ZERO;
    current_window_hyst = PCT_ZERO;
    signed_window_upper = PCT_FULL;
    signed_window_lower = PCT_NFULL;
    signed_window_hyst = PCT_ZERO;
  endtask

  // Wait past the sample, comparator and command stages and the select synchroniser
  task automatic settle();
    repeat (6) @(posedge sys_clk);
    #1;
  endtask

  task automatic run(input int v, input int i, input int b, input int n);
    vi = v;
    ii = i;
    bi = b;
    src_u.push(SAMPLE_W'(v), SAMPLE_W'(i), SAMPLE_W'(b), n);
    settle();
  endtask

  // Expected command from source codes, select state and the last readings
  function automatic void predict();
    int p, mn, val;
    logic s, bm;
    p = (pair_select_param > PAIR_B_K) ? 0 : int'(pair_select_param);
    s = analog_type_select;
    if (!select_assigned) begin
      bm = (trim_mode_param == TRIM_NONE);
      mn = bm ? bi : vi + ii;
      e_trm = (trim_mode_param == TRIM_UNI) || (trim_mode_param == TRIM_REV);
      e_rvp = bm || (trim_mode_param == TRIM_REV);
    end else begin
      case (p)
        0: mn = s ? ii : vi;
        1: mn = s ? bi : vi;
        2: mn = s ? int'(keypad_pot_input) : vi;
        3: mn = s ? int'(keypad_pot_input) : ii;
        default: mn = s ? int'(keypad_pot_input) : bi;
      endcase
      bm = (p == 1 && s) || (p == 4 && !s);
      e_trm = !bm && (p > 1 || trim_mode_param == TRIM_UNI || trim_mode_param == TRIM_REV);
      e_rvp = (bm || (p < 2 && trim_mode_param == TRIM_REV)) && trim_mode_param != TRIM_UNI;
    end
    val = mn + (e_trm ? bi : 0);
    // The block saturates a trimmed sum at full scale
    if (val > int'(PCT_FULL)) begin
      val = int'(PCT_FULL);
    end
    e_vld = (frequency_source_param == FSRC_ANALOG);
    e_rev = e_vld && e_rvp && val < 0;
    e_mag = !e_vld ? '0 : (val >= 0) ? SAMPLE_W'(val) : e_rvp ? SAMPLE_W'(-val) : '0;
  endfunction

  task automatic check_cmd();
    predict();
    chk_bit(command_valid, e_vld, "valid");
    chk_val(command_magnitude, e_mag);
    if (e_vld) begin
      chk_bit(command_reverse, e_rev, "reverse");
      chk_bit(trim_active, e_trm, "trim");
      chk_bit(reverse_permitted, e_rvp, "rev ok");
    end
  endtask

  // Watchdog: the tests need a few thousand cycles
  initial begin
    #2000000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  // Main sequence
  initial begin
    wide();
    void'($urandom(32'h099659FE));
    repeat (8) @(posedge sys_clk);
    #1;
    chk_bit(command_valid, 1'b0, "reset valid");
    chk_val(command_magnitude, '0);
    rst_n = 1'b1;
    $display("reset test done");
    // Hysteresis and substitution on the voltage window
    voltage_window_upper = 12'sh320;
    voltage_window_lower = 12'sh0C8;
    voltage_window_hyst = 12'sh032;
    for (int j = 0; j < 9; j++) begin
      run(wv[j], 0, 0, 1);
      chk_bit(voltage_window_flag, wf[j], "volt flag");
      chk_val(command_magnitude, SAMPLE_W'(wm[j]));
    end
    // Narrow window: upper is raised, oversize hysteresis is clipped
    voltage_window_upper = 12'sh12C;
    for (int h = 0; h < 2; h++) begin
      voltage_window_hyst = h ? 12'sh096 : HYST_MAX;
      run(100, 0, 0, 1);
      run(300, 0, 0, 1);
      chk_bit(voltage_window_flag, 1'b1, "narrow flag");
    end
    $display("window test done");
    // Moving average of length 4 on three inputs at once
    wide();
    input_filter_param = 5'h04;
    src_u.push(12'sh064, 12'sh028, -12'sh0C8, 1);
    src_u.push(12'sh0C8, 12'sh050, 12'sh064, 1);
    src_u.push(12'sh12C, 12'sh078, -12'sh12C, 1);
    src_u.push(12'sh191, 12'sh0A3, -12'sh02A, 1);
    settle();
    chk_val(command_magnitude, 12'h0FA);
    analog_type_select = 1'b1;
    settle();
    chk_val(command_magnitude, 12'h064);
    // Signed average truncates toward zero: (-200 + 100 - 300 - 42) / 4 is -110
    select_assigned = 1'b0;
    trim_mode_param = TRIM_NONE;
    settle();
    chk_val(command_magnitude, 12'h06E);
    chk_bit(command_reverse, 1'b1, "negative average");
    $display("filter test done");
    // Every pair, trim, select and assignment combination, random readings
    for (int c = 0; c < 128; c++) begin
      @(posedge sys_clk);
      #1;
      pair_select_param = c[2:0];
      trim_mode_param = c[4:3];
      analog_type_select = c[5];
      select_assigned = c[6];
      frequency_source_param = (c % 5 == 4) ? 2'($urandom_range(3)) : FSRC_ANALOG;
      input_filter_param = FILT_W'($urandom_range(30, 1));
      keypad_pot_input = SAMPLE_W'($urandom_range(600));
      run($urandom_range(400), $urandom_range(400), int'($urandom_range(600)) - 300,
          int'(input_filter_param));
      check_cmd();
      chk_bit(current_window_flag, 1'b1, "curr flag");
      chk_bit(signed_window_flag, 1'b1, "sign flag");
    end
    $display("selection test done");
    close_out();
  end
endmodule // test_analog_input_select_window_compare
